// ==== core/pcb_pkg.sv ====
// What this block does
// [R1] registers take byte, word or dword; address register only as full dword
// [R2] multi-byte fields are little-endian: lowest byte lane holds least significant byte
// [R3] writes to read-only registers change nothing and have no side effect
// [R4] write-one-to-clear bits: 1 clears, 0 leaves the bit alone
// [R5] reserved config locations complete normally and read as zero
// [R6] software avoids writing reserved device-specific locations above offset 3Fh
// [R7] hard reset loads every internal config register with its default
// [R8] host software keeps address/data access pairs atomic between processors
// [R9] address register at I/O 0CF8h, resets to zero; partial access passes to PCI
// [R10] bit 31 of the address register enables configuration cycles
// [R11] bus 0 device 0 is served internally with no PCI cycle
// [R12] only function 0 is claimed; other functions give type 0 with no IDSEL
// [R13] data window at 0CFCh maps I/O into config space while enabled
// [R14] only mechanism #1, type 0 and type 1 cycles
// [R15] type 0: bits 10:2 to AD[10:2], device n asserts only AD[11+n]
// [R16] type 0 devices above 20 run with no IDSEL, ending in master abort
// [R17] nonzero bus: type 1, bits 23:2 to AD[23:2], AD[1:0]=01, rest zero
// [R18] each function holds at most 256 bytes addressed by dword register number
// [R19] data window accesses with enable clear pass to PCI as plain I/O
package pcb_pkg;
  // ==========================================================
  // host i/o map
  localparam logic [15:0] PCB_IO_CONF_ADDR = 16'h0CF8;
  localparam logic [15:0] PCB_IO_CONF_DATA = 16'h0CFC;
  localparam logic [31:0] PCB_CONF_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] PCB_CONF_ADDR_MASK = 32'h80FF_FFFC;
  localparam int PCB_EN_BIT = 31;
  localparam int PCB_MAX_DEV = 20;
  // ==========================================================
  // pci command codes
  localparam logic [3:0] PCB_CMD_IO_RD = 4'h2;
  localparam logic [3:0] PCB_CMD_IO_WR = 4'h3;
  localparam logic [3:0] PCB_CMD_CFG_RD = 4'hA;
  localparam logic [3:0] PCB_CMD_CFG_WR = 4'hB;
  localparam logic [1:0] PCB_TYPE1_CODE = 2'b01;
  // ==========================================================
  // own config space, dword indices
  localparam logic [5:0] PCB_IDX_ID = 6'h00;
  localparam logic [5:0] PCB_IDX_CMD_STS = 6'h01;
  localparam logic [5:0] PCB_IDX_CLASS = 6'h02;
  localparam logic [5:0] PCB_IDX_MISC = 6'h03;
  localparam logic [15:0] PCB_VENDOR_CODE = 16'h1F2E; // arbitrary value
  localparam logic [15:0] PCB_DEVICE_CODE = 16'h0A5C; // arbitrary value
  localparam logic [7:0] PCB_REVISION = 8'h01; // arbitrary value
  localparam logic [23:0] PCB_CLASS_CODE = 24'h06_0000;
  localparam logic [15:0] PCB_CMD_FIXED = 16'h0006;
  localparam logic [15:0] PCB_STS_FIXED = 16'h0280;
  localparam int PCB_CMD_PERR_BIT = 6;
  localparam int PCB_CMD_SERR_BIT = 8;
  localparam int PCB_STS_DPD_BIT = 8;
  localparam logic [4:0] PCB_MLT_RST = 5'h00;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcb_host_req_s;
  typedef struct packed {
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcb_pci_req_s;
  // hardware status events, one-cycle pulses
  typedef struct packed {
    logic parity_det;
    logic sys_err;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
    logic data_parity;
  } pcb_evt_s;
endpackage : pcb_pkg

// ==== core/pcb_cfg_regs.sv ====
`timescale 1ns/1ns
module pcb_cfg_regs import pcb_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_wr_en,
  input wire logic [5:0] i_reg_idx,
  input wire logic [3:0] i_be,
  input wire logic [31:0] i_wdata,
  input wire pcb_evt_s i_evt,
  output logic [31:0] o_rdata,
  output logic o_perr_en,
  output logic o_serr_en,
  output logic [4:0] o_mlt
);
  // ==========================================================
  // state
  logic perr_en_q;
  logic serr_en_q;
  logic [4:0] mlt_q;
  logic [5:0] sts_q; // {parity, sys err, m abort, t abort rx, t abort tx, data parity}
  logic [5:0] sts_set;
  logic [5:0] sts_clr;
  logic [15:0] sts_word;
  logic [15:0] cmd_word;

  // write one-to-clear masks from byte lane 3
  always_comb begin
    sts_set = {i_evt.parity_det, i_evt.sys_err && serr_en_q, i_evt.master_abort,
               i_evt.target_abort_rx, i_evt.target_abort_tx, i_evt.data_parity && perr_en_q};
    sts_clr = 6'h00;
    if (i_wr_en && i_reg_idx == PCB_IDX_CMD_STS) begin
      if (i_be[3]) sts_clr[5:1] = i_wdata[31:27]; // R2
      if (i_be[3]) sts_clr[0] = i_wdata[24];
    end
  end

  // status flags, a set in the clear cycle wins
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sts_q <= 6'h00; // R7
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set; // R4
    end
  end

  // command and latency timer writes, lane by lane
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      perr_en_q <= 1'b0; // R7
      serr_en_q <= 1'b0;
      mlt_q <= PCB_MLT_RST;
    end else if (i_wr_en) begin
      if (i_reg_idx == PCB_IDX_CMD_STS && i_be[0]) perr_en_q <= i_wdata[PCB_CMD_PERR_BIT];
      if (i_reg_idx == PCB_IDX_CMD_STS && i_be[1]) serr_en_q <= i_wdata[PCB_CMD_SERR_BIT];
      if (i_reg_idx == PCB_IDX_MISC && i_be[1]) mlt_q <= i_wdata[15:11];
    end
  end

  // read mux; identity and class words ignore writes, indices above 03h read zero
  always_comb begin
    cmd_word = PCB_CMD_FIXED;
    cmd_word[PCB_CMD_PERR_BIT] = perr_en_q;
    cmd_word[PCB_CMD_SERR_BIT] = serr_en_q;
    sts_word = PCB_STS_FIXED | {sts_q[5:1], 11'h000};
    sts_word[PCB_STS_DPD_BIT] = sts_q[0];
    case (i_reg_idx)
      PCB_IDX_ID: o_rdata = {PCB_DEVICE_CODE, PCB_VENDOR_CODE}; // R3
      PCB_IDX_CMD_STS: o_rdata = {sts_word, cmd_word}; // R2
      PCB_IDX_CLASS: o_rdata = {PCB_CLASS_CODE, PCB_REVISION};
      PCB_IDX_MISC: o_rdata = {16'h0000, mlt_q, 3'b000, 8'h00};
      default: o_rdata = 32'h0000_0000; // R5
    endcase
  end

  assign o_perr_en = perr_en_q;
  assign o_serr_en = serr_en_q;
  assign o_mlt = mlt_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_rwc_clear: assert property ( // R4
    (i_wr_en && i_reg_idx == PCB_IDX_CMD_STS && i_be[3] && i_wdata[31] && !i_evt.parity_det)
      |=> !sts_q[5])
    else $error("status bit not cleared by write of one");
  a_rwc_keep: assert property ( // R4
    (i_wr_en && i_reg_idx == PCB_IDX_CMD_STS && !i_wdata[31] && sts_q[5]) |=> sts_q[5])
    else $error("status bit lost on write of zero");
endmodule : pcb_cfg_regs

// ==== core/pcb_bridge.sv ====
`timescale 1ns/1ns
module pcb_bridge import pcb_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire pcb_host_req_s i_host,
  output logic o_io_ack,
  output logic [31:0] o_io_rdata,
  output logic o_pci_req,
  output pcb_pci_req_s o_pci,
  input wire logic i_pci_done,
  input wire logic [31:0] i_pci_rdata,
  input wire pcb_evt_s i_evt,
  output logic o_perr_en,
  output logic o_serr_en,
  output logic [4:0] o_mlt,
  output logic [31:0] o_conf_addr
);
  // ==========================================================
  // types and helpers
  typedef enum logic [1:0] {
    PCB_ST_IDLE = 2'b01,
    PCB_ST_PCI = 2'b10
  } pcb_state_e;

  // byte offset of the lowest enabled lane
  function automatic logic [1:0] first_lane(input logic [3:0] be);
    if (be[0]) first_lane = 2'd0;
    else if (be[1]) first_lane = 2'd1;
    else if (be[2]) first_lane = 2'd2;
    else first_lane = 2'd3;
  endfunction : first_lane

  // config cycle address from the address register
  function automatic logic [31:0] cfg_address(input logic [31:0] ca);
    logic [31:0] a;
    logic [4:0] dev;
    a = 32'h0000_0000;
    dev = ca[15:11];
    if (ca[23:16] != 8'h00) begin
      a = {8'h00, ca[23:2], PCB_TYPE1_CODE}; // R17
    end else begin
      a[10:2] = ca[10:2]; // R15
      if (dev != 5'd0 && dev <= 5'(PCB_MAX_DEV)) a[5'd11 + dev] = 1'b1; // R15 R16
    end
    cfg_address = a;
  endfunction : cfg_address

  // ==========================================================
  // decode of the current host request
  pcb_state_e state_q;
  logic [31:0] conf_addr_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic pci_req_q;
  pcb_pci_req_s pci_q;
  logic at_addr;
  logic at_data;
  logic addr_dword;
  logic cfg_en;
  logic own_target;
  logic take;
  logic own_acc;
  logic addr_acc;
  logic [31:0] own_rdata;

  always_comb begin
    take = i_host.req && state_q == PCB_ST_IDLE;
    at_addr = i_host.addr[15:2] == PCB_IO_CONF_ADDR[15:2];
    at_data = i_host.addr[15:2] == PCB_IO_CONF_DATA[15:2];
    addr_dword = i_host.be == 4'hF; // R1
    cfg_en = conf_addr_q[PCB_EN_BIT]; // R10
    own_target = conf_addr_q[23:16] == 8'h00 && conf_addr_q[15:8] == 8'h00; // R11 R12
    addr_acc = take && at_addr && addr_dword; // R9
    own_acc = take && at_data && cfg_en && own_target; // R11 R13
  end

  // ==========================================================
  // address register, dword access only
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      conf_addr_q <= PCB_CONF_ADDR_RST; // R9 R7
    end else if (addr_acc && i_host.wr) begin
      conf_addr_q <= i_host.wdata & PCB_CONF_ADDR_MASK; // R9
    end
  end

  // ==========================================================
  // own config registers, register number picks the dword
  pcb_cfg_regs u_cfg_regs (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_wr_en(own_acc && i_host.wr),
    .i_reg_idx(conf_addr_q[7:2]), // R18
    .i_be(i_host.be),
    .i_wdata(i_host.wdata),
    .i_evt(i_evt),
    .o_rdata(own_rdata),
    .o_perr_en(o_perr_en),
    .o_serr_en(o_serr_en),
    .o_mlt(o_mlt)
  );

  // ==========================================================
  // sequencer: local answers in one cycle, pci accesses wait for done
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= PCB_ST_IDLE;
    end else begin
      case (state_q)
        PCB_ST_IDLE: begin
          if (take && !addr_acc && !own_acc) state_q <= PCB_ST_PCI;
        end
        PCB_ST_PCI: begin
          if (i_pci_done) state_q <= PCB_ST_IDLE;
        end
        default: state_q <= PCB_ST_IDLE;
      endcase
    end
  end

  // pci request build; mechanism #1 only, everything else is plain i/o
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pci_req_q <= 1'b0;
      pci_q <= '0;
    end else if (take && !addr_acc && !own_acc) begin
      pci_req_q <= 1'b1;
      pci_q.be <= i_host.be;
      pci_q.wdata <= i_host.wdata;
      if (at_data && cfg_en) begin
        pci_q.cmd <= i_host.wr ? PCB_CMD_CFG_WR : PCB_CMD_CFG_RD; // R13 R14
        pci_q.addr <= cfg_address(conf_addr_q); // R12 R15 R16 R17
      end else begin
        pci_q.cmd <= i_host.wr ? PCB_CMD_IO_WR : PCB_CMD_IO_RD; // R9 R19
        pci_q.addr <= {16'h0000, i_host.addr[15:2], first_lane(i_host.be)};
      end
    end else if (state_q == PCB_ST_PCI && i_pci_done) begin
      pci_req_q <= 1'b0;
    end
  end

  // host answer: one-cycle ack with registered read data
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= addr_acc || own_acc || (state_q == PCB_ST_PCI && i_pci_done);
      if (addr_acc) begin
        rdata_q <= conf_addr_q;
      end else if (own_acc) begin
        rdata_q <= own_rdata; // R2 R5
      end else if (state_q == PCB_ST_PCI && i_pci_done) begin
        rdata_q <= i_pci_rdata;
      end
    end
  end

  assign o_io_ack = ack_q;
  assign o_io_rdata = rdata_q;
  assign o_pci_req = pci_req_q;
  assign o_pci = pci_q;
  assign o_conf_addr = conf_addr_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_pci_issued(logic [3:0] c);
    o_pci_req && o_pci.cmd == c;
  endsequence
  sequence s_local_answer;
    !o_pci_req && o_io_ack;
  endsequence

  a_addr_dword_wr: assert property ( // R9
    (addr_acc && i_host.wr) |=> o_conf_addr == ($past(i_host.wdata) & PCB_CONF_ADDR_MASK) ##0 o_io_ack)
    else $error("address register not loaded by dword write");
  a_addr_partial_fwd: assert property ( // R9
    (take && at_addr && !addr_dword && !i_host.wr) |=> s_pci_issued(PCB_CMD_IO_RD))
    else $error("partial address access not passed to pci");
  a_own_no_pci: assert property ( // R11
    own_acc |=> s_local_answer)
    else $error("own config access reached pci");
  a_disabled_io: assert property ( // R19
    (take && at_data && !cfg_en && i_host.wr) |=> s_pci_issued(PCB_CMD_IO_WR))
    else $error("disabled window access not plain i/o");
  a_type0_idsel: assert property ( // R15
    (o_pci_req && o_pci.cmd[3:1] == 3'b101 && o_pci.addr[1:0] == 2'b00)
      |-> ($onehot0(o_pci.addr[31:11]) && !o_pci.addr[11] && o_pci.addr[10:2] == o_conf_addr[10:2]))
    else $error("type 0 idsel wrong");
  a_type1_code: assert property ( // R17
    ($rose(o_pci_req) && o_pci.cmd[3:1] == 3'b101 && o_conf_addr[23:16] != 8'h00)
      |-> o_pci.addr == {8'h00, o_conf_addr[23:2], 2'b01})
    else $error("type 1 address wrong");
  a_dev_over20: assert property ( // R16
    ($rose(o_pci_req) && o_pci.cmd[3:1] == 3'b101 && o_conf_addr[23:16] == 8'h00
      && o_conf_addr[15:11] > 5'd20) |-> o_pci.addr[31:11] == 21'h00_0000)
    else $error("idsel asserted for device above 20");
  a_func_abort: assert property ( // R12
    (take && at_data && cfg_en && o_conf_addr[23:11] == 13'h0000 && o_conf_addr[10:8] != 3'b000)
      |=> o_pci_req && o_pci.addr[31:11] == 21'h00_0000)
    else $error("nonzero function not sent without idsel");
  a_req_holds: assert property ( // R13
    (o_pci_req && !i_pci_done) |=> o_pci_req && $stable(o_pci.addr))
    else $error("pci request dropped early");
  a_ack_after_done: assert property ( // R13
    (o_pci_req && i_pci_done) |=> o_io_ack && !o_pci_req ##1 !o_io_ack)
    else $error("host not answered after pci done");
  a_partial_wr_fwd: assert property ( // R9
    (take && at_addr && !addr_dword && i_host.wr) |=> s_pci_issued(PCB_CMD_IO_WR))
    else $error("partial address write not passed to pci");
  a_partial_keeps: assert property ( // R1
    (take && at_addr && !addr_dword) |=> $stable(o_conf_addr))
    else $error("partial access changed the address register");
  a_cfg_rd_issue: assert property ( // R13 R14
    (take && at_data && cfg_en && !own_target && !i_host.wr) |=> s_pci_issued(PCB_CMD_CFG_RD))
    else $error("enabled window read not a config read");
  a_cfg_wr_issue: assert property ( // R13 R14
    (take && at_data && cfg_en && !own_target && i_host.wr) |=> s_pci_issued(PCB_CMD_CFG_WR))
    else $error("enabled window write not a config write");
  a_disabled_rd: assert property ( // R19
    (take && at_data && !cfg_en && !i_host.wr) |=> s_pci_issued(PCB_CMD_IO_RD))
    else $error("disabled window read not plain i/o");
  a_ack_single: assert property ( // R13
    o_io_ack |=> !o_io_ack)
    else $error("host answer longer than one cycle");
  a_no_ack_pending: assert property ( // R13
    (o_pci_req && !i_pci_done) |=> !o_io_ack)
    else $error("host answered before pci done");
  a_pci_data_kept: assert property ( // R13
    (o_pci_req && !i_pci_done) |=> $stable(o_pci.wdata) && $stable(o_pci.be))
    else $error("pci write data changed while pending");
endmodule : pcb_bridge

// ==== testbench/pcb_pci_target_model.sv ====
`timescale 1ns/1ns
// ==========
// pci engine and targets behind the bridge
module pcb_pci_target_model import pcb_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_pci_req,
  input wire pcb_pci_req_s i_pci,
  input wire logic [1:0] i_delay,
  output logic o_pci_done,
  output logic [31:0] o_pci_rdata
);
  logic hit;
  // one cycle at a time, answered after i_delay cycles
  initial begin
    o_pci_done = 1'b0;
    o_pci_rdata = 32'h0000_0000;
    forever begin
      @(posedge i_sys_clk);
      #1;
      if (i_pci_req === 1'b1) begin
        repeat (i_delay) begin
          @(posedge i_sys_clk);
          #1;
        end
        // type 0 with no idsel line is never claimed
        hit = !(i_pci.cmd[3] && i_pci.addr[1:0] == 2'b00 && i_pci.addr[31:11] == 21'h0);
        o_pci_rdata = hit ? ~i_pci.addr : 32'hFFFF_FFFF;
        o_pci_done = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_pci_done = 1'b0;
        o_pci_rdata = ~o_pci_rdata; // bus released
      end
    end
  end
endmodule : pcb_pci_target_model

// ==== testbench/test_pci_config_access_bridge.sv ====
`timescale 1ns/1ns
module test_pci_config_access_bridge import pcb_pkg::*; ;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  pcb_host_req_s host;
  pcb_pci_req_s pci, p;
  pcb_evt_s evt;
  logic ack, pci_req, done, perr, serr, req_d, w;
  logic [31:0] rdata, prd, conf, r, v, c, e;
  logic [4:0] mlt;
  logic [1:0] dly;
  int error_cnt = 0;
  int num_checks = 0;
  int lat, d;
  pcb_pci_req_s pq[$];
  // ==========
  // design and far side
  pcb_bridge pcb_bridge_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_host(host), .o_io_ack(ack),
    .o_io_rdata(rdata), .o_pci_req(pci_req), .o_pci(pci), .i_pci_done(done), .i_pci_rdata(prd),
    .i_evt(evt), .o_perr_en(perr), .o_serr_en(serr), .o_mlt(mlt), .o_conf_addr(conf));
  pcb_pci_target_model pcb_pci_target_model_i (.i_sys_clk(i_sys_clk), .i_pci_req(pci_req), .i_pci(pci),
    .i_delay(dly), .o_pci_done(done), .o_pci_rdata(prd));
  always #5 i_sys_clk = ~i_sys_clk;
  // queue every pci cycle as it starts
  always @(posedge i_sys_clk) begin
    req_d <= pci_req;
    if (pci_req === 1'b1 && req_d !== 1'b1) pq.push_back(pci);
  end
  // ==========
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd,
                     output logic [31:0] rd);
    host = '{1'b1, wr, a, be, wd};
    lat = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      lat++;
    end while (ack !== 1'b1 && lat < 50);
    rd = rdata;
    host.req = 1'b0;
    if (lat >= 50) chk(32'h0000_0000, 32'h0000_0001);
    @(posedge i_sys_clk);
    #1;
  endtask : acc
  task automatic pop(output pcb_pci_req_s q);
    chk(32'(pq.size()), 32'h0000_0001);
    q = (pq.size() > 0) ? pq.pop_front() : '0;
    pq.delete();
  endtask : pop
  function automatic logic [31:0] exp_addr(input logic [31:0] cv);
    int dn;
    dn = cv[15:11];
    if (cv[23:16] != 8'h00) return {8'h00, cv[23:2], 2'b01};
    return ((dn >= 1 && dn <= 20) ? (32'h0000_0001 << (11 + dn)) : 32'h0000_0000) | {21'h0, cv[10:2], 2'b00};
  endfunction : exp_addr
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // watchdog
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  // ==========
  // tests
  initial begin
    host = '0;
    evt = '0;
    dly = 2'd0;
    r = $urandom(32'h0000_ee25);
    repeat (10) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    chk(conf, 32'h0000_0000);
    acc(1'b0, PCB_IO_CONF_ADDR, 4'hF, 32'h0, r);
    chk(r, 32'h0000_0000);
    v = $urandom;
    acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, v, r);
    chk(conf, v & PCB_CONF_ADDR_MASK);
    acc(1'b0, PCB_IO_CONF_ADDR, 4'hF, 32'h0, r);
    chk(r, v & PCB_CONF_ADDR_MASK);
    acc(1'b1, PCB_IO_CONF_ADDR, 4'h1, 32'h0000_0055, r);
    pop(p);
    chk({p.cmd, p.addr[27:0]}, {PCB_CMD_IO_WR, 28'h000_0CF8});
    chk(conf, v & PCB_CONF_ADDR_MASK);
    acc(1'b0, PCB_IO_CONF_ADDR, 4'h4, 32'h0, r);
    pop(p);
    chk({p.cmd, p.be, p.addr[23:0]}, {PCB_CMD_IO_RD, 4'h4, 24'h00_0CFA});
    chk(r, ~32'h0000_0CFA);
    $display("test address register done");
    acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, 32'h8000_0000, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hF, 32'h0, r);
    chk(r, {PCB_DEVICE_CODE, PCB_VENDOR_CODE});
    chk(32'(lat), 32'h0000_0001);
    chk(32'(pq.size()), 32'h0000_0000);
    acc(1'b0, PCB_IO_CONF_DATA, 4'h2, 32'h0, r);
    chk({24'h0, r[15:8]}, {24'h0, PCB_VENDOR_CODE[15:8]});
    acc(1'b1, PCB_IO_CONF_DATA, 4'hF, 32'hFFFF_FFFF, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hF, 32'h0, r);
    chk(r, {PCB_DEVICE_CODE, PCB_VENDOR_CODE});
    acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, 32'h8000_0004, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hF, 32'h0, r);
    chk(r, {PCB_STS_FIXED, PCB_CMD_FIXED});
    acc(1'b1, PCB_IO_CONF_DATA, 4'h3, 32'h0000_0140, r);
    chk({30'h0, perr, serr}, 32'h0000_0003);
    evt = 6'h3F; // every status event at once
    @(posedge i_sys_clk);
    #1;
    evt = '0;
    acc(1'b1, PCB_IO_CONF_DATA, 4'hC, 32'h0000_0000, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hF, 32'h0, r);
    chk(r, {PCB_STS_FIXED | 16'hF900, PCB_CMD_FIXED | 16'h0140});
    acc(1'b1, PCB_IO_CONF_DATA, 4'hC, 32'h2000_0000, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hC, 32'h0, r);
    chk({16'h0, r[31:16]}, {16'h0, PCB_STS_FIXED | 16'hD900});
    acc(1'b1, PCB_IO_CONF_DATA, 4'hC, 32'hD900_0000, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hC, 32'h0, r);
    chk({16'h0, r[31:16]}, {16'h0, PCB_STS_FIXED});
    acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, 32'h8000_000C, r);
    acc(1'b1, PCB_IO_CONF_DATA, 4'h2, 32'h0000_FF00, r);
    chk({27'h0, mlt}, 32'h0000_001F);
    acc(1'b0, PCB_IO_CONF_DATA, 4'h2, 32'h0, r);
    chk({24'h0, r[15:8]}, 32'h0000_00F8);
    acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, 32'h8000_0010, r);
    acc(1'b1, PCB_IO_CONF_DATA, 4'hF, 32'hA5A5_A5A5, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hF, 32'h0, r);
    chk(r, 32'h0000_0000);
    $display("test own registers done");
    acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, 32'h8000_0104, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hF, 32'h0, r);
    pop(p);
    chk({p.cmd, p.addr[27:0]}, {PCB_CMD_CFG_RD, 28'h000_0104});
    chk(r, 32'hFFFF_FFFF);
    for (int i = 0; i < 24; i++) begin
      d = (i < 2) ? 20 + i : 1 + $urandom % 23;
      c = {1'b1, 7'h0, (i % 3 == 2) ? 8'(1 + $urandom % 255) : 8'h00, 5'(d), 3'($urandom), 6'($urandom), 2'b00};
      w = 1'($urandom);
      v = $urandom;
      dly = 2'($urandom);
      acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, c, r);
      acc(w, PCB_IO_CONF_DATA, 4'hF, v, r);
      pop(p);
      e = exp_addr(c);
      chk(p.addr, e);
      chk({28'h0, p.cmd}, {28'h0, w ? PCB_CMD_CFG_WR : PCB_CMD_CFG_RD});
      chk({28'h0, p.be}, 32'h0000_000F);
      if (w) chk(p.wdata, v);
      else chk(r, (c[23:16] != 8'h00 || d <= 20) ? ~e : 32'hFFFF_FFFF);
    end
    $display("test pci config cycles done");
    acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, 32'h0000_0000, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'hF, 32'h0, r);
    pop(p);
    chk({p.cmd, p.addr[27:0]}, {PCB_CMD_IO_RD, 28'h000_0CFC});
    chk(r, ~32'h0000_0CFC);
    v = $urandom;
    acc(1'b1, PCB_IO_CONF_DATA, 4'h6, v, r);
    pop(p);
    chk({p.cmd, p.be, p.addr[23:0]}, {PCB_CMD_IO_WR, 4'h6, 24'h00_0CFD});
    chk(p.wdata, v);
    $display("test disabled window done");
    i_reset = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_reset = 1'b0;
    chk(conf, 32'h0000_0000);
    chk({25'h0, mlt, perr, serr}, 32'h0000_0000);
    acc(1'b1, PCB_IO_CONF_ADDR, 4'hF, 32'h8000_000C, r);
    acc(1'b0, PCB_IO_CONF_DATA, 4'h2, 32'h0, r);
    chk(r, 32'h0000_0000);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : test_pci_config_access_bridge
